/* include/obl_regs.svh */
`ifndef OBL_REGS_SVH
`define OBL_REGS_SVH
`define OBL_OFS_WDT_OSC 16'h0080
`define OBL_OFS_POC 16'h0081
`define OBL_OFS_RSV_A 16'h0082
`define OBL_OFS_RSV_B 16'h0083
`define OBL_OFS_DEBUG 16'h0084
`define OBL_OFS_SWAP_BASE 16'h1080
`define OBL_OFS_STATUS 16'h0090
`define OBL_OPT_COUNT 3'h5
`define OBL_BIT_WIN_HI 6
`define OBL_BIT_WIN_LO 5
`define OBL_BIT_WDT_RUN 4
`define OBL_BIT_OVF_HI 3
`define OBL_BIT_OVF_LO 1
`define OBL_BIT_OSC_LOCK 0
`define OBL_BIT_POC_MODE 0
`define OBL_BIT_DBG_HI 1
`define OBL_BIT_DBG_LO 0
`define OBL_OVF_BASE_EXP 5'h0a
`define OBL_RST_BYTE 8'h00
`endif

/* include/obl_pkg.sv */
package obl_pkg;
  typedef enum logic [2:0] {
    OBL_IDLE = 3'h0,
    OBL_REQ = 3'h1,
    OBL_WAIT = 3'h3,
    OBL_DONE = 3'h2
  } obl_state_t;
  typedef enum logic [1:0] {
    OBL_DBG_OFF = 2'h0,
    OBL_DBG_BAD = 2'h1,
    OBL_DBG_KEEP = 2'h2,
    OBL_DBG_ERASE = 2'h3
  } obl_dbg_t;
  typedef struct packed {
    logic [1:0] wdt_open_span;
    logic wdt_run_at_reset;
    logic [2:0] wdt_overflow_sel;
    logic [4:0] wdt_overflow_exp;
    logic lowspeed_osc_lock;
    logic poweron_clear_mode_sel;
    obl_dbg_t debug_mode;
    logic debug_enable;
    logic debug_erase_on_fail;
    logic bad_combo;
  } obl_cfg_t;
endpackage : obl_pkg

/* hdl/obl_byte_latch.sv */
`timescale 1ns/100ps
`default_nettype none
`include "obl_regs.svh"
module obl_byte_latch (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  output logic [7:0] q_o
);
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_o <= `OBL_RST_BYTE;
    end else if (load_i) begin
      q_o <= data_i;
    end
  end
endmodule : obl_byte_latch
`default_nettype wire

/* hdl/obl_option_loader.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "obl_regs.svh"
module obl_option_loader
  import obl_pkg::*;
#(
  parameter int FLASH_LAT = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic boot_swap_i,
  input wire logic self_prog_i,
  output logic flash_rd_o,
  output logic [15:0] flash_addr_o,
  input wire logic flash_valid_i,
  input wire logic [7:0] flash_data_i,
  input wire logic lowspeed_osc_stop_req_i,
  input wire logic halt_i,
  input wire logic stop_i,
  input wire logic timer_h1_on_lowspeed_i,
  output logic lowspeed_osc_run_o,
  output logic wdt_clk_en_o,
  output logic timer_h1_clk_en_o,
  output logic poc_copy_wr_o,
  output logic [7:0] poc_copy_data_o,
  output obl_cfg_t cfg_o,
  output logic load_done_o,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);
  obl_state_t state_r;
  logic [2:0] idx_r;
  logic [7:0] bytes_q [5];
  logic [4:0] load_v;
  logic [7:0] opt0;
  logic [7:0] opt1;
  logic [7:0] opt4;
  logic [7:0] poc_byte;
  logic [2:0] ovf;
  logic swap_r;
  logic unused_wdata;

  assign unused_wdata = |reg_wdata_i;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= OBL_IDLE;
      idx_r <= 3'h0;
    end else begin
      unique case (state_r)
        OBL_IDLE: begin
          state_r <= OBL_REQ;
        end
        OBL_REQ: begin
          state_r <= OBL_WAIT;
        end
        OBL_WAIT: begin
          if (flash_valid_i) begin
            if (idx_r == `OBL_OPT_COUNT - 3'h1) begin
              state_r <= OBL_DONE;
            end else begin
              idx_r <= idx_r + 3'h1;
              state_r <= OBL_REQ;
            end
          end
        end
        OBL_DONE: begin
          state_r <= OBL_DONE;
        end
      endcase
    end
  end

  // swap strap caught after release, held for the whole run
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      swap_r <= 1'b0;
    end else if (state_r == OBL_IDLE) begin
      swap_r <= boot_swap_i;
    end
  end

  assign flash_rd_o = (state_r == OBL_REQ);
  assign flash_addr_o = (swap_r ? `OBL_OFS_SWAP_BASE : `OBL_OFS_WDT_OSC) + {13'h0, idx_r};

  for (genvar g = 0; g < 5; g++) begin : g_byte
    assign load_v[g] = (state_r == OBL_WAIT) && flash_valid_i && (idx_r == 3'(g));
    obl_byte_latch u_latch (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .load_i(load_v[g]),
      .data_i(flash_data_i),
      .q_o(bytes_q[g])
    );
  end

  assign opt0 = bytes_q[0];
  assign opt1 = bytes_q[1];
  assign opt4 = bytes_q[4];
  assign ovf = opt0[`OBL_BIT_OVF_HI:`OBL_BIT_OVF_LO];

  // mode bit from self-programmed flash is ignored
  assign poc_byte = self_prog_i ? `OBL_RST_BYTE : opt1;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      poc_copy_wr_o <= 1'b0;
      poc_copy_data_o <= `OBL_RST_BYTE;
    end else begin
      poc_copy_wr_o <= swap_r && load_v[1];
      if (swap_r && load_v[1]) begin
        poc_copy_data_o <= flash_data_i;
      end
    end
  end

  always_comb begin
    cfg_o.wdt_open_span = opt0[`OBL_BIT_WIN_HI:`OBL_BIT_WIN_LO];
    cfg_o.wdt_run_at_reset = opt0[`OBL_BIT_WDT_RUN];
    cfg_o.wdt_overflow_sel = ovf;
    cfg_o.wdt_overflow_exp = `OBL_OVF_BASE_EXP + {2'h0, ovf};
    cfg_o.lowspeed_osc_lock = opt0[`OBL_BIT_OSC_LOCK];
    cfg_o.poweron_clear_mode_sel = poc_byte[`OBL_BIT_POC_MODE];
    cfg_o.debug_mode = obl_dbg_t'(opt4[`OBL_BIT_DBG_HI:`OBL_BIT_DBG_LO]);
    cfg_o.debug_enable = opt4[`OBL_BIT_DBG_HI];
    cfg_o.debug_erase_on_fail = (opt4[`OBL_BIT_DBG_HI:`OBL_BIT_DBG_LO] == OBL_DBG_ERASE);
    cfg_o.bad_combo = (ovf == 3'h0) && (opt0[`OBL_BIT_WIN_HI:`OBL_BIT_WIN_LO] == 2'h0);
  end

  assign load_done_o = (state_r == OBL_DONE);

  assign lowspeed_osc_run_o = cfg_o.lowspeed_osc_lock || !lowspeed_osc_stop_req_i;

  // count clock gated in low power unless locked
  // self-programming does not gate the count
  assign wdt_clk_en_o = load_done_o && lowspeed_osc_run_o &&
                        (cfg_o.lowspeed_osc_lock || !(halt_i || stop_i));

  // timer keeps low-speed clock in halt/stop
  assign timer_h1_clk_en_o = timer_h1_on_lowspeed_i && lowspeed_osc_run_o;

  // read-only view; writes have no effect
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OBL_OFS_WDT_OSC: reg_rdata_o <= opt0;
        `OBL_OFS_POC: reg_rdata_o <= poc_byte;
        `OBL_OFS_RSV_A: reg_rdata_o <= bytes_q[2];
        `OBL_OFS_RSV_B: reg_rdata_o <= bytes_q[3];
        `OBL_OFS_DEBUG: reg_rdata_o <= opt4;
        `OBL_OFS_STATUS: reg_rdata_o <= {5'h0, cfg_o.bad_combo, swap_r, load_done_o};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  sequence s_fetch;
    flash_rd_o ##1 (state_r == OBL_WAIT);
  endsequence

  AST_FETCH_PULSE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    flash_rd_o |-> s_fetch)
    else $error("read strobe not followed by wait");
  AST_DONE_STABLE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    load_done_o |=> load_done_o && $stable(opt0) && $stable(opt4))
    else $error("settings changed after load");
  AST_DONE_AFTER_LAST: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(load_done_o) |-> $past(load_v[4]))
    else $error("done without last byte");
  AST_SWAP_ADDR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    flash_rd_o && swap_r |-> flash_addr_o[12])
    else $error("swap area not used");
  AST_OSC_LOCK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cfg_o.lowspeed_osc_lock |-> lowspeed_osc_run_o)
    else $error("locked oscillator stopped");
  AST_WDT_GATE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !cfg_o.lowspeed_osc_lock && (halt_i || stop_i) |-> !wdt_clk_en_o)
    else $error("count clock in low power");
  AST_POC_COPY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    swap_r && load_v[1] |=> poc_copy_wr_o && poc_copy_data_o == $past(flash_data_i))
    else $error("poc copy missing");
  AST_OVF_EXP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    load_done_o |-> cfg_o.wdt_overflow_exp == 5'(opt0[3:1]) + 5'd10)
    else $error("overflow exponent wrong");
  AST_POC_SELF: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    self_prog_i |-> !cfg_o.poweron_clear_mode_sel)
    else $error("mode set under self-programming");
endmodule : obl_option_loader
`default_nettype wire

/* verif/obl_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module obl_flash_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [39:0] pri_i,
  input wire logic [39:0] alt_i,
  input wire logic [1:0] dly_i,
  output logic valid_o,
  output logic [7:0] data_o
);
  logic pend_r;
  logic [1:0] cnt_r;
  logic [15:0] addr_r;
  logic [7:0] sel_w;
  assign sel_w = addr_r[12] ? alt_i[addr_r[2:0]*8 +: 8] : pri_i[addr_r[2:0]*8 +: 8];
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= 1'b0;
      cnt_r <= 2'h0;
      addr_r <= 16'h0000;
      valid_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      if (rd_i) begin
        pend_r <= 1'b1;
        cnt_r <= dly_i;
        addr_r <= addr_i;
      end else if (pend_r && cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end
      // idle bus toggles so a stale byte is never mistaken for data
      if (pend_r && !rd_i && cnt_r == 2'h0) begin
        valid_o <= 1'b1;
        data_o <= sel_w;
        pend_r <= 1'b0;
      end else begin
        valid_o <= 1'b0;
        data_o <= ~data_o;
      end
    end
  end
endmodule : obl_flash_model
`default_nettype wire

/* verif/obl_option_loader_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module obl_option_loader_tb
  import obl_pkg::*;
;
  localparam logic [39:0] IMG_A = 40'h0200000030;
  localparam logic [39:0] IMG_B = 40'h030000016f;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic boot_swap_i, self_prog_i, fl_rd, fl_valid, stop_req, halt, stop, h1;
  logic osc_run, wdt_en, h1_en, poc_wr, done, rw_s, rd_s, poc_seen;
  logic [15:0] fl_addr, ra;
  logic [7:0] fl_data, poc_data, poc_val, wd, rdata;
  logic [39:0] pri, alt;
  logic [1:0] dly;
  obl_cfg_t cfg;
  int mismatches = 0;
  int checks_done = 0;
  int nval, i;
  always #5 clock_i = ~clock_i;
  obl_option_loader DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .boot_swap_i(boot_swap_i),
    .self_prog_i(self_prog_i), .flash_rd_o(fl_rd), .flash_addr_o(fl_addr),
    .flash_valid_i(fl_valid), .flash_data_i(fl_data), .lowspeed_osc_stop_req_i(stop_req),
    .halt_i(halt), .stop_i(stop), .timer_h1_on_lowspeed_i(h1), .lowspeed_osc_run_o(osc_run),
    .wdt_clk_en_o(wdt_en), .timer_h1_clk_en_o(h1_en), .poc_copy_wr_o(poc_wr),
    .poc_copy_data_o(poc_data), .cfg_o(cfg), .load_done_o(done), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(rw_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata));
  obl_flash_model FLASH (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .rd_i(fl_rd),
    .addr_i(fl_addr), .pri_i(pri), .alt_i(alt), .dly_i(dly), .valid_o(fl_valid),
    .data_o(fl_data));
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      nval <= 0;
      poc_seen <= 1'b0;
    end else begin
      if (fl_valid && done !== 1'b1) nval <= nval + 1;
      if (poc_wr === 1'b1) begin
        poc_seen <= 1'b1;
        poc_val <= poc_data;
      end
    end
  end
  function automatic obl_cfg_t ecfg(input logic [7:0] b0, b1, b4, input logic sp);
    obl_cfg_t c;
    c = {b0[6:5], b0[4], b0[3:1], 5'h0a + {2'h0, b0[3:1]}, b0[0], b1[0] & ~sp,
      obl_dbg_t'(b4[1:0]), b4[1], &b4[1:0], (b0[6:5] == 2'h0) && (b0[3:1] == 3'h0)};
    return c;
  endfunction : ecfg
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic boot(input logic sw, input logic [1:0] d);
    int k;
    boot_swap_i <= sw;
    dly <= d;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (k = 0; k < 100 && done !== 1'b1; k++) @(posedge clock_i);
    #1;
    chk("bytes", {done, nval[30:0]}, 32'h80000005);
  endtask : boot
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock_i);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 chk("reg", rdata, e);
  endtask : rreg
  task automatic gate(input logic [2:0] hsq, input logic [1:0] e);
    halt <= hsq[2];
    stop <= hsq[1];
    stop_req <= hsq[0];
    @(posedge clock_i);
    #1 chk("osc", {osc_run, h1_en, wdt_en}, {e[1], e[1], e[0]});
  endtask : gate
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    {boot_swap_i, self_prog_i, stop_req, halt, stop, rw_s, rd_s} <= 7'h00;
    {ra, wd, dly} <= 26'h0;
    h1 <= 1'b1;
    pri <= IMG_A;
    // swap copy differs on purpose so the chosen area is visible
    alt <= IMG_B;
    boot(1'b0, 2'h0);
    chk("cfg", {14'h0, cfg}, {14'h0, ecfg(8'h30, 8'h00, 8'h02, 1'b0)});
    for (i = 0; i < 5; i++) rreg(16'h0080 + i[15:0], IMG_A[i*8 +: 8]);
    wd <= 8'hff;
    @(posedge clock_i);
    rw_s <= 1'b1;
    ra <= 16'h0080;
    @(posedge clock_i);
    rw_s <= 1'b0;
    rreg(16'h0080, 8'h30);
    rreg(16'h0085, 8'h00);
    rreg(16'h0090, 8'h01);
    gate(3'b000, 2'b11);
    gate(3'b100, 2'b10);
    gate(3'b010, 2'b10);
    gate(3'b001, 2'b00);
    self_prog_i <= 1'b1;
    pri <= IMG_B;
    gate(3'b000, 2'b11);
    repeat (4) @(posedge clock_i);
    chk("held", {14'h0, cfg}, {14'h0, ecfg(8'h30, 8'h00, 8'h02, 1'b1)});
    $display("test primary done");
    self_prog_i <= 1'b0;
    pri <= IMG_A;
    boot(1'b1, 2'h2);
    chk("swcfg", {14'h0, cfg}, {14'h0, ecfg(8'h6f, 8'h01, 8'h03, 1'b0)});
    chk("poc", {poc_seen, poc_val}, 9'h101);
    rreg(16'h0090, 8'h03);
    gate(3'b101, 2'b11);
    self_prog_i <= 1'b1;
    @(posedge clock_i);
    #1 chk("spcfg", {14'h0, cfg}, {14'h0, ecfg(8'h6f, 8'h01, 8'h03, 1'b1)});
    $display("test swap done");
    self_prog_i <= 1'b0;
    boot(1'b0, 2'h1);
    chk("recfg", {14'h0, cfg}, {14'h0, ecfg(8'h30, 8'h00, 8'h02, 1'b0)});
    $display("test reload done");
    end_sim();
  end
endmodule : obl_option_loader_tb
`default_nettype wire
